// file: rtl/srdc_defines.svh
// register offsets, field positions and reset values of the switch route / debug config block
`ifndef SRDC_DEFINES_SVH
`define SRDC_DEFINES_SVH
`define SRDC_OFF_DIR_LOWER    8'h0c
`define SRDC_OFF_DIR_UPPER    8'h0d
`define SRDC_OFF_DBG_CFG      8'h10
`define SRDC_RST_DIR          32'h0000_0000
`define SRDC_RST_DBG_CFG      2'h0
`define SRDC_BIT_PULLDOWN_EN  0
`define SRDC_BIT_DEBUG_CALL_TRAP_EN     1
`define SRDC_DIR_W            4
`define SRDC_NODE_ID_W        16
`endif

// file: rtl/srdc_pkg.sv
// types shared by the switch route / debug config block
package srdc_pkg;
	typedef logic [3:0] srdc_dir_t;
	typedef struct packed {
		logic [15:0] dest_id;
		logic [15:0] tag;
	} srdc_req_t;
	typedef struct packed {
		logic        local_hit;
		srdc_dir_t   dir;
		logic [15:0] tag;
	} srdc_rsp_t;
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [31:0] wdata;
	} srdc_cfg_t;
endpackage

// file: rtl/srdc_route_config.sv
// routing decision and debug line configuration of a switch node
`timescale 1ns/100ps
`default_nettype none
`include "srdc_defines.svh"

// Functional notes
// R1: mismatch in id bits 15..8 routes by direction of most significant differing bit.
// R2: upper table: eight nibbles, bits 31:28 for bit 15 down to 3:0 for bit 8.
// R3: all direction fields read/write by configuration access, reset to zero.
// R4: debug call enable bit 1 lets debug line activity raise a core trap.
// R5: pull-down enable bit 0 pulls debug line low when node enters debug mode.
// R6: debug config enables reset zero; bits 31:2 reserved, read as zero.
// R7: mismatch in bits 7..0 uses lower table with same most-significant rule.
// R8: host reaches these registers only through configuration reads and writes.
// R9: debug line is open drain active low: only released or pulled low.
module srdc_route_config #(
	parameter int ID_W = `SRDC_NODE_ID_W
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              srst,
	// configuration access
	input  wire logic              cfg_valid,
	input  wire srdc_pkg::srdc_cfg_t cfg_req,
	output logic                   cfg_ack,
	output logic [31:0]            cfg_rdata,
	// node identity
	input  wire logic [ID_W-1:0]   node_id,
	// route requests
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire srdc_pkg::srdc_req_t req_data,
	// route answers
	output logic                   rsp_valid,
	input  wire logic              rsp_ready,
	output srdc_pkg::srdc_rsp_t    rsp_data,
	// debug line and core
	input  wire logic              debug_mode,
	input  wire logic              debug_line_n_i,
	output logic                   debug_line_n_o,
	output logic                   debug_line_n_oe,
	output logic                   debug_call_trap
);
	import srdc_pkg::*;

	// configuration state
	logic [31:0] dir_lo_q;
	logic [31:0] dir_lo_d;
	logic [31:0] dir_hi_q;
	logic [31:0] dir_hi_d;
	logic [1:0]  dbg_cfg_q;
	logic [1:0]  dbg_cfg_d;
	logic        ack_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	// configuration decode
	wire         sel_lo  = (cfg_req.addr == `SRDC_OFF_DIR_LOWER);
	wire         sel_hi  = (cfg_req.addr == `SRDC_OFF_DIR_UPPER);
	wire         sel_dbg = (cfg_req.addr == `SRDC_OFF_DBG_CFG);
	wire         is_wr   = cfg_valid && cfg_req.wr;
	wire         is_rd   = cfg_valid && !cfg_req.wr;
	wire         wr_lo   = is_wr && sel_lo;
	wire         wr_hi   = is_wr && sel_hi;
	wire         wr_dbg  = is_wr && sel_dbg;
	wire [31:0]  dbg_rd  = {30'h0, dbg_cfg_q}; // [R6]
	wire [31:0]  rd_mux  = sel_lo  ? dir_lo_q :
	                       sel_hi  ? dir_hi_q :
	                       sel_dbg ? dbg_rd :
	                       32'h0;

	assign dir_lo_d  = wr_lo ? cfg_req.wdata : dir_lo_q; // [R3] [R7]
	assign dir_hi_d  = wr_hi ? cfg_req.wdata : dir_hi_q; // [R3] [R2]
	assign dbg_cfg_d = wr_dbg ? cfg_req.wdata[1:0] : dbg_cfg_q; // [R6]
	assign rdata_d   = is_rd ? rd_mux : 32'h0;

	always_ff @(posedge clk) begin
		if (srst) begin
			dir_lo_q <= `SRDC_RST_DIR;
		end else begin
			dir_lo_q <= dir_lo_d;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			dir_hi_q <= `SRDC_RST_DIR;
		end else begin
			dir_hi_q <= dir_hi_d;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			dbg_cfg_q <= `SRDC_RST_DBG_CFG;
		end else begin
			dbg_cfg_q <= dbg_cfg_d;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			ack_q   <= cfg_valid;
			rdata_q <= rdata_d;
		end
	end

	assign cfg_ack   = ack_q;
	assign cfg_rdata = rdata_q;

	// most significant mismatch search, one lane per id bit
	wire [15:0]  diff = req_data.dest_id ^ node_id[15:0];
	wire [15:0]  above; // some id bit above this lane differs
	wire [3:0]   lane_dir [16];
	wire [15:0]  lane_hit;
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_lane
			if (g == 15) begin : g_top
				assign above[g] = 1'b0;
			end else begin : g_rest
				assign above[g] = above[g+1] | diff[g+1];
			end
			if (g >= 8) begin : g_hi
				assign lane_dir[g] = dir_hi_q[(g - 8) * 4 +: 4]; // [R2]
			end else begin : g_lo
				assign lane_dir[g] = dir_lo_q[g * 4 +: 4]; // [R7]
			end
			assign lane_hit[g] = diff[g] && !above[g]; // [R1] [R7]
		end
	endgenerate

	logic [3:0]  pick_dir;
	always_comb begin
		pick_dir = 4'h0;
		for (int i = 0; i < 16; i++) begin
			pick_dir = pick_dir | (lane_dir[i] & {4{lane_hit[i]}}); // [R1]
		end
	end

	// answer word for the request on the input side
	srdc_rsp_t   new_rsp;
	assign new_rsp.local_hit = (diff == 16'h0);
	assign new_rsp.dir       = pick_dir; // [R1]
	assign new_rsp.tag       = req_data.tag;

	// two-entry skid buffer: output stage plus one spare entry
	srdc_rsp_t   out_q;
	srdc_rsp_t   out_d;
	srdc_rsp_t   skid_q;
	srdc_rsp_t   skid_d;
	logic        out_vld_q;
	logic        out_vld_d;
	logic        skid_vld_q;
	logic        skid_vld_d;
	logic        rdy_q;
	wire         push = req_valid && rdy_q;
	wire         pop  = out_vld_q && rsp_ready;
	wire         take = pop || !out_vld_q; // output stage free this cycle

	always_comb begin
		out_vld_d  = out_vld_q;
		out_d      = out_q;
		skid_vld_d = skid_vld_q;
		skid_d     = skid_q;
		if (take && skid_vld_q) begin
			out_vld_d  = 1'b1;
			out_d      = skid_q;
			skid_vld_d = 1'b0;
		end else if (take) begin
			out_vld_d = push;
			if (push) begin
				out_d = new_rsp;
			end
		end else if (push) begin
			skid_vld_d = 1'b1;
			skid_d     = new_rsp;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			out_vld_q  <= 1'b0;
			skid_vld_q <= 1'b0;
			rdy_q      <= 1'b1;
			out_q      <= '0;
			skid_q     <= '0;
		end else begin
			out_vld_q  <= out_vld_d;
			skid_vld_q <= skid_vld_d;
			rdy_q      <= !skid_vld_d;
			out_q      <= out_d;
			skid_q     <= skid_d;
		end
	end

	assign req_ready = rdy_q;
	assign rsp_valid = out_vld_q;
	assign rsp_data  = out_q;

	// debug line: pull low only, sample for trap
	logic        dbg_in_q;
	logic        dbg_oe_q;
	logic        trap_q;
	wire         pull_d = debug_mode && dbg_cfg_q[`SRDC_BIT_PULLDOWN_EN]; // [R5]
	wire         fall   = dbg_in_q && !debug_line_n_i; // wire went from high to low
	wire         trap_d = dbg_cfg_q[`SRDC_BIT_DEBUG_CALL_TRAP_EN] && fall; // [R4]

	always_ff @(posedge clk) begin
		if (srst) begin
			dbg_oe_q <= 1'b0;
		end else begin
			dbg_oe_q <= pull_d; // [R5] [R9]
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			dbg_in_q <= 1'b1;
		end else begin
			dbg_in_q <= debug_line_n_i;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			trap_q <= 1'b0;
		end else begin
			trap_q <= trap_d; // [R4]
		end
	end

	assign debug_line_n_o  = 1'b0; // [R9]
	assign debug_line_n_oe = dbg_oe_q;
	assign debug_call_trap = trap_q;
endmodule
`default_nettype wire

// file: test/srdc_props.sv
// assertions on the ports of the route and debug config block
`timescale 1ns/100ps
`default_nettype none
module srdc_props (
	input wire logic clk, srst, cfg_valid, cfg_ack, rsp_valid, rsp_ready,
	input wire logic debug_mode, debug_line_n_i, debug_line_n_o, debug_line_n_oe,
	input wire logic debug_call_trap,
	input wire logic [31:0] cfg_rdata,
	input wire srdc_pkg::srdc_cfg_t cfg_req,
	input wire srdc_pkg::srdc_rsp_t rsp_data
);
	import srdc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	property p_ack; cfg_valid |=> cfg_ack; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_rsv; cfg_valid && !cfg_req.wr && cfg_req.addr == 8'h10
		|=> cfg_rdata[31:2] == 30'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved set");
	property p_oe; debug_line_n_oe |-> $past(debug_mode); endproperty
	a_oe: assert property (p_oe) else $error("stray pull");
	property p_low; !debug_line_n_o; endproperty
	a_low: assert property (p_low) else $error("driven high");
	property p_trap; debug_call_trap |-> $past(debug_line_n_i, 2) && !$past(debug_line_n_i);
		endproperty
	a_trap: assert property (p_trap) else $error("stray trap");
	property p_pulse; debug_call_trap |=> !debug_call_trap; endproperty
	a_pulse: assert property (p_pulse) else $error("long trap");
	property p_stall; rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data); endproperty
	a_stall: assert property (p_stall) else $error("lost answer");
	property p_hit; rsp_valid && rsp_data.local_hit |-> rsp_data.dir == 4'h0; endproperty
	a_hit: assert property (p_hit) else $error("hit with dir");
endmodule
`default_nettype wire

// file: test/srdc_far.sv
// far side: answer consumer and another node on the debug wire
`timescale 1ns/100ps
`default_nettype none
module srdc_far (
	input  wire logic hold,
	input  wire logic pull,
	output logic      rsp_ready,
	output logic      pull_oe
);
	assign rsp_ready = !hold;
	assign pull_oe = pull;
endmodule
`default_nettype wire

// file: test/tb_switch_route_debug_config.sv
// self-checking bench of the route and debug config block
`timescale 1ns/100ps
`default_nettype none
module tb_switch_route_debug_config;
	import srdc_pkg::*;
	logic clk = 0, srst = 1, cfg_valid = 0, req_valid = 0, debug_mode = 0, hold = 1, pull = 0;
	logic cfg_ack, req_ready, rsp_valid, rsp_ready, debug_line_n_o, debug_line_n_oe;
	logic debug_call_trap, pull_oe;
	logic [31:0] cfg_rdata, rd;
	logic [15:0] node_id = 16'h5a3c;
	logic [20:0] rows [6];
	srdc_cfg_t cfg_req = '0;
	srdc_req_t req_data = '0;
	srdc_rsp_t rsp_data;
	int failures = 0, checked = 0, cyc = 0;
	// pulled-up wire, low while any node pulls
	wire logic debug_line_n_i = !(debug_line_n_oe && !debug_line_n_o || pull_oe);
	srdc_route_config srdc_route_config_inst (.*);
	srdc_far srdc_far_inst (.*);
	initial forever #2.5 clk = !clk;
	always @(posedge clk) if (++cyc == 2000) begin failures++; results; end
	task cmp(input logic [31:0] g, e);
		checked++;
		if (g !== e) begin failures++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end
	endtask
	task cfg(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(negedge clk) cfg_valid = 1;
		cfg_req = '{w, a, d};
		@(negedge clk) cfg_valid = 0;
		rd = cfg_rdata;
		cmp(cfg_ack, 1);
	endtask
	task req(input logic [15:0] d, t);
		@(negedge clk) req_valid = 1;
		req_data = '{d, t};
	endtask
	task rsp(input logic [20:0] e);
		repeat (4) if (!rsp_valid) @(negedge clk);
		cmp({rsp_valid, rsp_data}, {1'b1, e});
	endtask
	task results;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		logic [7:0] ad [4] = '{8'h0c, 8'h0d, 8'h10, 8'h11};
		rows = '{{node_id ^ 16'h8000, 5'h08}, {node_id ^ 16'h0300, 5'h02},
			{node_id ^ 16'h0180, 5'h01}, {node_id ^ 16'h0080, 5'h0f},
			{node_id ^ 16'h0001, 5'h08}, {node_id, 5'h10}};
		repeat (4) @(negedge clk);
		srst = 0;
		foreach (ad[i]) begin cfg(0, ad[i], 0); cmp(rd, 0); end
		cfg(1, 8'h10, 32'hffff_ffff);
		cfg(0, 8'h10, 0);
		cmp(rd, 32'h3);
		cfg(1, 8'h0d, 32'h8765_4321);
		cfg(1, 8'h0c, 32'hfedc_ba98);
		cfg(0, 8'h0d, 0);
		cmp(rd, 32'h8765_4321);
		$display("registers done");
		hold = 0;
		foreach (rows[i]) begin
			req(rows[i][20:5], 16'(i));
			@(negedge clk) req_valid = 0;
			rsp({rows[i][4:0], 16'(i)});
		end
		$display("routing done");
		@(negedge clk) hold = 1;
		req(node_id ^ 16'h4000, 16'h00a1);
		req(node_id ^ 16'h2000, 16'h00a2);
		@(negedge clk) req_valid = 0;
		cmp(req_ready, 0);
		hold = 0;
		rsp({5'h07, 16'h00a1});
		@(negedge clk) rsp({5'h06, 16'h00a2});
		$display("buffer done");
		cfg(1, 8'h10, 32'h3);
		debug_mode = 1;
		@(negedge clk) cmp(debug_line_n_oe, 1);
		@(negedge clk) cmp(debug_call_trap, 1);
		debug_mode = 0;
		cfg(1, 8'h10, 32'h0);
		debug_mode = 1;
		pull = 1;
		repeat (3) @(negedge clk) cmp({debug_line_n_oe, debug_call_trap}, 0);
		pull = 0;
		cfg(1, 8'h10, 32'h2);
		pull = 1;
		@(negedge clk) cmp({debug_line_n_oe, debug_call_trap}, 1);
		pull = 0;
		$display("debug line done");
		srst = 1;
		@(negedge clk) srst = 0;
		cmp({req_ready, rsp_valid, cfg_ack}, 3'h4);
		cfg(0, 8'h0d, 0);
		cmp(rd, 0);
		$display("reset done");
		results;
	end
endmodule
bind srdc_route_config srdc_props srdc_props_inst (.*);
`default_nettype wire
